// ---- design/oss_params.svh ----
/*
 * Constants for the output safe-state selector: sizes, reset values, timing.
 * Assumes the including file compiles it once; the guard protects against repeats.
 */
`ifndef OSS_PARAMS_SVH
`define OSS_PARAMS_SVH

// =====================================================================
// Sizes
`define OSS_NUM_OUTPUTS 4
`define OSS_LIMIT_WIDTH 16

// =====================================================================
// Reset values
`define OSS_OUT_RESET 1'b0

// =====================================================================
// Timing: the loss limit counts in ticks of one millisecond.
`define OSS_CLK_PERIOD_NS 8
`define OSS_TICK_NS 1000000
`define OSS_TICK_CYCLES (`OSS_TICK_NS / `OSS_CLK_PERIOD_NS)

`endif

// ---- design/oss_pkg.sv ----
/*
 * Types shared by the output safe-state selector and its loss timer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */

// =====================================================================
// Controller mode and per-output safe-state action
package oss_pkg;

    typedef enum logic [1:0] {
        OSS_RUN     = 2'b00,
        OSS_PROGRAM = 2'b01,
        OSS_FAULT   = 2'b10
    } oss_mode_t;

    typedef enum logic [1:0] {
        OSS_HOLD = 2'b00,
        OSS_LOW  = 2'b01,
        OSS_HIGH = 2'b10
    } oss_action_t;

endpackage : oss_pkg

// ---- design/oss_loss_timer.sv ----
/*
 * Communication-loss timer: a millisecond tick divider and a saturating
 * count of ticks since communication was lost.
 * Assumes commOk and lossLimit are synchronous to core_clk.
 */
`timescale 1ns/1ps
`include "oss_params.svh"

module oss_loss_timer #(
    parameter int TICK_CYCLES = `OSS_TICK_CYCLES,
    parameter int LIMIT_W = `OSS_LIMIT_WIDTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Link status and limit
    input wire logic commOk,
    input wire logic [LIMIT_W-1:0] lossLimit,
    // Result
    output logic expired
);
    import oss_pkg::*;

    localparam int CW = $clog2(TICK_CYCLES + 1);

    // =================================================================
    // Elaboration check
    if (TICK_CYCLES < 1 || LIMIT_W < 1) begin : g_bad
        $error("oss_loss_timer: TICK_CYCLES and LIMIT_W must be at least 1");
    end

    logic [CW-1:0] tickCnt, next_tickCnt;
    logic [LIMIT_W-1:0] elapsed, next_elapsed;
    logic next_expired;

    // =================================================================
    // Tick divider and elapsed count; both restart while the link is good,
    // so every loss is timed from its own start.
    always_comb begin
        next_tickCnt = tickCnt;
        next_elapsed = elapsed;
        if (commOk) begin
            next_tickCnt = '0;
            next_elapsed = '0;
        end else if (tickCnt == CW'(TICK_CYCLES - 1)) begin
            next_tickCnt = '0;
            if (elapsed != {LIMIT_W{1'b1}}) begin
                next_elapsed = elapsed + LIMIT_W'(1);
            end
        end else begin
            next_tickCnt = tickCnt + CW'(1);
        end
        // Strictly longer than the limit selects the extended set.
        next_expired = !commOk && (elapsed > lossLimit);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tickCnt <= '0;
            elapsed <= '0;
            expired <= 1'b0;
        end else begin
            tickCnt <= next_tickCnt;
            elapsed <= next_elapsed;
            expired <= next_expired;
        end
    end

    // =================================================================
    // Checks
    sequence s_rise;
        !commOk ##1 $rose(expired);
    endsequence

    chk_expire_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_rise |-> $past(elapsed) > $past(lossLimit))
        else $error("extended set entered before the loss limit passed");

    chk_expire_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        commOk |=> !expired)
        else $error("extended set still active after communication returned");

endmodule : oss_loss_timer

// ---- design/oss_output_safe_select.sv ----
/*
 * Output safe-state selector: chooses the driven level of each discrete
 * output from normal control, program, fault, loss and force settings.
 * Assumes all inputs are synchronous to core_clk and configuration is static
 * or changes between cycles like any other input.
 */
`timescale 1ns/1ps
`include "oss_params.svh"

// Function
// - In program mode each output holds, goes low or goes high as configured.
// - In fault mode each output holds, goes low or goes high as configured.
// - On communication loss each output selects program or fault behaviour.
// - A loss lasting beyond the limit switches to the extended action set.
// - Every output has its own independent force function.
// - Force enable set drives the output from its force value.
module oss_output_safe_select #(
    parameter int NUM_OUTPUTS = `OSS_NUM_OUTPUTS,
    parameter int LIMIT_W = `OSS_LIMIT_WIDTH,
    parameter int TICK_CYCLES = `OSS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Owner controller status and data
    input wire oss_pkg::oss_mode_t ctrlMode,
    input wire logic commOk,
    input wire logic [NUM_OUTPUTS-1:0] normalData,
    // Safe-state configuration
    input wire oss_pkg::oss_action_t [NUM_OUTPUTS-1:0] progAction,
    input wire oss_pkg::oss_action_t [NUM_OUTPUTS-1:0] faultAction,
    input wire oss_pkg::oss_action_t [NUM_OUTPUTS-1:0] extAction,
    input wire logic [NUM_OUTPUTS-1:0] lossUseFault,
    input wire logic [LIMIT_W-1:0] lossLimit,
    // Force controls
    input wire logic [NUM_OUTPUTS-1:0] outputForceEnable,
    input wire logic [NUM_OUTPUTS-1:0] outputForceValue,
    // Outputs and status
    output logic [NUM_OUTPUTS-1:0] outData,
    output logic lossActive,
    output logic extActive
);
    import oss_pkg::*;

    // =================================================================
    // Elaboration check
    if (NUM_OUTPUTS < 1) begin : g_bad
        $error("oss_output_safe_select: NUM_OUTPUTS must be at least 1");
    end

    logic [NUM_OUTPUTS-1:0] ctrlData, next_ctrlData;
    logic [NUM_OUTPUTS-1:0] next_outData;
    logic next_lossActive;

    // Maps an action onto a level; hold keeps the pre-force level that control last gave.
    function automatic logic apply_action(input oss_action_t act, input logic held);
        logic lvl;
        lvl = held;
        case (act)
            OSS_LOW: lvl = 1'b0;
            OSS_HIGH: lvl = 1'b1;
            default: lvl = held;
        endcase
        return lvl;
    endfunction : apply_action

    // =================================================================
    // Loss timer; extActive comes from its flip-flop.
    oss_loss_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .LIMIT_W(LIMIT_W)
    ) u_timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .commOk(commOk),
        .lossLimit(lossLimit),
        .expired(extActive)
    );

    // =================================================================
    // Per-output selection. The held state is the pre-force level, so a
    // force lifted during hold returns the output to what control last gave.
    for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
        always_comb begin
            if (!commOk) begin
                if (extActive) begin
                    next_ctrlData[i] = apply_action(extAction[i], ctrlData[i]);
                end else if (lossUseFault[i]) begin
                    next_ctrlData[i] = apply_action(faultAction[i], ctrlData[i]);
                end else begin
                    next_ctrlData[i] = apply_action(progAction[i], ctrlData[i]);
                end
            end else begin
                case (ctrlMode)
                    OSS_RUN: next_ctrlData[i] = normalData[i];
                    OSS_PROGRAM: begin
                        next_ctrlData[i] = apply_action(progAction[i], ctrlData[i]);
                    end
                    // An undefined mode code is treated as a fault, the safer choice.
                    default: begin
                        next_ctrlData[i] = apply_action(faultAction[i], ctrlData[i]);
                    end
                endcase
            end
            // Force wins over every condition, one output at a time.
            if (outputForceEnable[i]) begin
                next_outData[i] = outputForceValue[i];
            end else begin
                next_outData[i] = next_ctrlData[i];
            end
        end
    end

    // =================================================================
    // Status next value.
    always_comb begin
        next_lossActive = !commOk;
    end

    // Registers for output levels and status.
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrlData <= {NUM_OUTPUTS{`OSS_OUT_RESET}};
            outData <= {NUM_OUTPUTS{`OSS_OUT_RESET}};
            lossActive <= 1'b0;
        end else begin
            ctrlData <= next_ctrlData;
            outData <= next_outData;
            lossActive <= next_lossActive;
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_chk
        sequence s_free;
            !outputForceEnable[i] && commOk;
        endsequence

        chk_run_follow: assert property (
            s_free and ctrlMode == OSS_RUN |=> outData[i] == $past(normalData[i]))
            else $error("running output did not follow normal data");

        // Code 11 holds like code 00, so only the two drive codes fix a level.
        chk_prog_level: assert property (
            s_free and ctrlMode == OSS_PROGRAM
            && (progAction[i] == OSS_LOW || progAction[i] == OSS_HIGH)
            |=> outData[i] == ($past(progAction[i]) == OSS_HIGH))
            else $error("program-state level wrong");

        chk_fault_hold: assert property (
            s_free and ctrlMode == OSS_FAULT && faultAction[i] == OSS_HOLD
            |=> outData[i] == $past(ctrlData[i]))
            else $error("fault hold did not keep the last level");

        chk_fault_level: assert property (
            s_free and ctrlMode == OSS_FAULT && faultAction[i] == OSS_HIGH |=> outData[i])
            else $error("fault-state high not driven");

        chk_loss_select: assert property (
            !outputForceEnable[i] && !commOk && !extActive && lossUseFault[i]
            && faultAction[i] == OSS_LOW |=> !outData[i])
            else $error("loss did not take fault behaviour");

        chk_loss_prog: assert property (
            !outputForceEnable[i] && !commOk && !extActive && !lossUseFault[i]
            && progAction[i] == OSS_HIGH |=> outData[i])
            else $error("loss did not take program behaviour");

        chk_ext_level: assert property (
            !outputForceEnable[i] && !commOk && extActive && extAction[i] == OSS_LOW
            |=> !outData[i])
            else $error("extended loss action not applied");

        chk_force_value: assert property (
            outputForceEnable[i] |=> outData[i] == $past(outputForceValue[i]))
            else $error("forced output not driven from force value");

        chk_force_keep: assert property (
            outputForceEnable[i] [*2] ##0 $stable(outputForceValue[i])
            |=> $stable(outData[i]))
            else $error("forced output moved while its force value stood");

        // Program hold keeps the level that control last gave, not a forced one.
        chk_prog_hold: assert property (
            s_free and ctrlMode == OSS_PROGRAM && progAction[i] == OSS_HOLD
            |=> outData[i] == $past(ctrlData[i]))
            else $error("program hold did not keep the last level");

        // The spare mode code must act as a fault, never as run.
        chk_spare_mode: assert property (
            s_free and ctrlMode == oss_mode_t'(2'b11) && faultAction[i] == OSS_LOW
            |=> !outData[i])
            else $error("spare mode code did not take fault behaviour");

        chk_loss_hold: assert property (
            !outputForceEnable[i] && !commOk && !extActive && lossUseFault[i]
            && faultAction[i] == OSS_HOLD |=> outData[i] == $past(ctrlData[i]))
            else $error("loss hold did not keep the last level");

        // Once the extended set is in force, per-output loss choices no longer apply.
        chk_ext_high: assert property (
            !outputForceEnable[i] && !commOk && extActive && extAction[i] == OSS_HIGH
            |=> outData[i])
            else $error("extended loss high not driven");

        chk_force_low: assert property (
            outputForceEnable[i] && !outputForceValue[i] |=> !outData[i])
            else $error("forced low output not driven low");
    end

    // The loss flag is a registered inverse of the link state, one cycle late.
    chk_loss_flag: assert property (
        !commOk |=> lossActive)
        else $error("loss flag not raised after communication was lost");

    chk_loss_clear: assert property (
        commOk |=> !lossActive)
        else $error("loss flag still raised after communication returned");

endmodule : oss_output_safe_select

// ---- verif/oss_owner_model.sv ----
/*
 * Owner-controller model: drives mode, link status, normal data and force controls.
 * Assumes the bench calls drive just after a falling edge of core_clk.
 */
`timescale 1ns/1ps

// =====================================================================
// Owner controller
module oss_owner_model #(
    parameter int N = 4
) (
    // Controller status and data
    output oss_pkg::oss_mode_t ctrlMode,
    output logic commOk,
    output logic [N-1:0] normalData,
    // Force controls
    output logic [N-1:0] outputForceEnable,
    output logic [N-1:0] outputForceValue
);
    import oss_pkg::*;

    // Value and enable change together, so a forced output never shows a stale level.
    task automatic drive(input oss_mode_t md, input logic cm, input logic [N-1:0] d, fe, fv);
        ctrlMode = md;
        commOk = cm;
        normalData = d;
        outputForceValue = fv;
        outputForceEnable = fe;
    endtask : drive

    // Running with the link up and nothing forced until told otherwise.
    initial begin
        drive(OSS_RUN, 1'b1, '0, '0, '0);
    end
endmodule : oss_owner_model

// ---- verif/oss_output_safe_select_tb.sv ----
/*
 * Self-checking bench for the output safe-state selector with a reference model.
 * Assumes the owner model drives controller signals and the loss tick is shortened.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) if ((got) !== (ex)) begin $display("wrong value %s exp %h got %h", nm, ex, got); miscompares++; end n_compared++;

// =====================================================================
// Bench top
module oss_output_safe_select_tb;
    import oss_pkg::*;
    localparam int N = 4;
    localparam int TICK = 4;
    logic core_clk;
    logic reset_n = 1'b0;
    oss_mode_t ctrlMode;
    logic commOk;
    logic [N-1:0] normalData, outputForceEnable, outputForceValue, lossUseFault, outData, held;
    oss_action_t [N-1:0] progAction, faultAction, extAction;
    logic [15:0] lossLimit = 16'h0001;
    logic lossActive, extActive, extRef;
    logic [N+1:0] expNote;
    logic [N+1:0] notes[$];
    int miscompares = 0;
    int n_compared = 0;
    int lossRun = 0;
    int limNext = 1;

    oss_output_safe_select #(.NUM_OUTPUTS(N), .LIMIT_W(16), .TICK_CYCLES(TICK)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .ctrlMode(ctrlMode), .commOk(commOk),
        .normalData(normalData), .progAction(progAction), .faultAction(faultAction),
        .extAction(extAction), .lossUseFault(lossUseFault), .lossLimit(lossLimit),
        .outputForceEnable(outputForceEnable), .outputForceValue(outputForceValue),
        .outData(outData), .lossActive(lossActive), .extActive(extActive));

    oss_owner_model #(.N(N)) owner (
        .ctrlMode(ctrlMode), .commOk(commOk), .normalData(normalData),
        .outputForceEnable(outputForceEnable), .outputForceValue(outputForceValue));

    // 125 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Code 11 falls through to hold, as the design treats it.
    function automatic logic act(input oss_action_t a, input logic h);
        return (a == OSS_LOW) ? 1'b0 : (a == OSS_HIGH) ? 1'b1 : h;
    endfunction : act

    // One cycle of stimulus with fresh random settings; the expected result is noted.
    task automatic step(input oss_mode_t md, input logic cm, input logic [N-1:0] d, fe, fv);
        logic [N-1:0] sel;
        @(negedge core_clk);
        lossLimit = 16'(limNext);
        for (int i = 0; i < N; i++) begin
            progAction[i] = oss_action_t'(2'($urandom));
            faultAction[i] = oss_action_t'(2'($urandom));
            extAction[i] = oss_action_t'(2'($urandom));
        end
        lossUseFault = N'($urandom);
        owner.drive(md, cm, d, fe, fv);
        for (int i = 0; i < N; i++) begin
            if (!cm) sel[i] = extRef ? act(extAction[i], held[i]) : lossUseFault[i] ?
                act(faultAction[i], held[i]) : act(progAction[i], held[i]);
            else if (md == OSS_RUN) sel[i] = d[i];
            else if (md == OSS_PROGRAM) sel[i] = act(progAction[i], held[i]);
            else sel[i] = act(faultAction[i], held[i]);
        end
        lossRun = cm ? 0 : lossRun + 1;
        extRef = !cm && (lossRun >= TICK * (int'(lossLimit) + 1) + 1);
        notes.push_back({extRef, !cm, (sel & ~fe) | (fv & fe)});
        held = sel;
    endtask : step

    // A loss held for TICK * (lim + 1) + extra steps, with the link left down at the end.
    task automatic long_loss(input int lim, input int extra);
        // The limit moves at the falling edge of the first loss step, so the
        // edge before it still sees the old limit, as the model assumes.
        limNext = lim;
        repeat (TICK * (lim + 1) + extra) step(OSS_RUN, 1'b0, N'($urandom), '0, '0);
    endtask : long_loss

    task automatic final_report;
        if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // Each note is checked one edge after it was driven, once outputs have settled.
    always @(posedge core_clk) begin
        #1;
        if (notes.size() > 0) begin
            expNote = notes.pop_front();
            `CHK("outData", expNote[N-1:0], outData)
            `CHK("lossActive", expNote[N], lossActive)
            `CHK("extActive", expNote[N+1], extActive)
        end
    end

    // A hang costs at most a few thousand cycles.
    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        final_report;
    end

    // =====================================================================
    // Main sequence
    initial begin
        void'($urandom(32'hfd9d));
        for (int i = 0; i < N; i++) begin
            progAction[i] = OSS_HOLD;
            faultAction[i] = OSS_HOLD;
            extAction[i] = OSS_HOLD;
        end
        lossUseFault = '0;
        held = '0;
        extRef = 1'b0;
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        // Random modes, links and forces, back to back, with code 11 included.
        repeat (300) step(oss_mode_t'(2'($urandom)), ($urandom % 8) != 0, N'($urandom),
            N'($urandom) & N'($urandom), N'($urandom));
        long_loss(0, 4);
        repeat (3) step(OSS_PROGRAM, 1'b1, '0, '0, '0);
        long_loss(3, 4);
        repeat (3) step(OSS_FAULT, 1'b1, '0, '0, '0);
        // A reset in mid-loss must clear the timer, so the next loss starts from zero.
        long_loss(1, -2);
        @(negedge core_clk);
        reset_n = 1'b0;
        // The link stays down through reset; hold actions make the release edge predictable.
        for (int i = 0; i < N; i++) begin
            progAction[i] = OSS_HOLD;
            faultAction[i] = OSS_HOLD;
            extAction[i] = OSS_HOLD;
        end
        repeat (2) @(negedge core_clk);
        `CHK("outData in reset", {N{1'b0}}, outData)
        `CHK("lossActive in reset", 1'b0, lossActive)
        `CHK("extActive in reset", 1'b0, extActive)
        held = '0;
        extRef = 1'b0;
        // The release edge already counts as the first edge of the new loss.
        lossRun = 1;
        reset_n = 1'b1;
        long_loss(1, 3);
        repeat (2) step(OSS_RUN, 1'b1, '1, '0, '0);
        // Let the last note be checked before the verdict.
        repeat (2) @(negedge core_clk);
        final_report;
    end
endmodule : oss_output_safe_select_tb
